// File: shared/fws_pkg.sv
/*
 * Shared constants for the flash write-status host controller: command
 * codes, unlock addresses, status bit positions, cycle timing, operations.
 * Assumes a 20 MHz system clock and a x16 parallel NOR flash bus.
 */
package fws_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 23;
    localparam int CMD_W = 8;
    localparam int UNLOCK_W = 12;

    // Command bytes of the flash command set
    localparam logic [CMD_W-1:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [CMD_W-1:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [CMD_W-1:0] CMD_PROGRAM = 8'hA0;
    localparam logic [CMD_W-1:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [CMD_W-1:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [CMD_W-1:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [CMD_W-1:0] CMD_RESET = 8'hF0;
    localparam logic [CMD_W-1:0] CMD_SUSPEND = 8'hB0;
    localparam logic [CMD_W-1:0] CMD_RESUME = 8'h30;

    localparam logic [UNLOCK_W-1:0] ADDR_UNLOCK1 = 12'h555;
    localparam logic [UNLOCK_W-1:0] ADDR_UNLOCK2 = 12'h2AA;

    // Status bit positions on the data bus
    localparam int BIT_DATA_POLL = 7;
    localparam int BIT_TOGGLE_ONE = 6;
    localparam int BIT_TIMING_LIMIT = 5;
    localparam int BIT_ERASE_WINDOW = 3;
    localparam int BIT_TOGGLE_TWO = 2;

    // Bus cycle timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_ACCESS_NS = 55;
    localparam int T_WRITE_PULSE_NS = 35;
    localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC =
        (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command sequence steps
    localparam logic [2:0] STEP_FIRST = 3'h0;
    localparam logic [2:0] STEP_PROG_LAST = 3'h3;
    localparam logic [2:0] STEP_FINAL = 3'h5;

    typedef enum logic [2:0] {
        OP_PROGRAM = 3'h0,
        OP_SECTOR_ERASE = 3'h1,
        OP_CHIP_ERASE = 3'h2,
        OP_ADD_SECTOR = 3'h3,
        OP_POLL = 3'h4,
        OP_SUSPEND = 3'h5,
        OP_RESUME = 3'h6,
        OP_RESET = 3'h7
    } fws_op_t;

endpackage

// File: logic/fws_bus_cycle.sv
/*
 * One asynchronous read or write cycle on the flash pins.
 * Assumes the flash data input is synchronous to clk_sys.
 */
`timescale 1ns/100ps
module fws_bus_cycle
    import fws_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W,
    parameter int RD_CYC = ACC_CYC,
    parameter int WR_CYC = WP_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic is_write,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic done,
    output logic [DW-1:0] rdata,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [AW-1:0] flash_addr,
    output logic [DW-1:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [DW-1:0] flash_dq_i
);

    typedef enum logic [3:0] {
        BC_IDLE = 4'h1,
        BC_SETUP = 4'h2,
        BC_STROBE = 4'h4,
        BC_HOLD = 4'h8
    } fws_bc_state_t;

    fws_bc_state_t state_q;
    logic wr_q;
    logic [3:0] cnt_q;
    wire logic [3:0] strobe_last;
    wire logic strobe_end;

    assign strobe_last = wr_q ? 4'(WR_CYC - 1) : 4'(RD_CYC - 1);
    assign strobe_end = (state_q == BC_STROBE) && (cnt_q == strobe_last);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= BC_IDLE;
            wr_q <= 1'b0;
            cnt_q <= 4'h0;
            done <= 1'b0;
            rdata <= '0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_addr <= '0;
            flash_dq_o <= '0;
            flash_dq_oe <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            case (state_q)
                BC_IDLE: begin
                    if (start) begin
                        wr_q <= is_write;
                        flash_addr <= addr;
                        flash_dq_o <= wdata;
                        flash_dq_oe <= is_write;
                        flash_ce_n <= 1'b0;
                        state_q <= BC_SETUP;
                    end
                end
                BC_SETUP: begin
                    flash_oe_n <= wr_q;
                    flash_we_n <= ~wr_q;
                    cnt_q <= 4'h0;
                    state_q <= BC_STROBE;
                end
                BC_STROBE: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (strobe_end) begin
                        // Data sampled on the edge that ends the strobe
                        if (!wr_q) begin
                            rdata <= flash_dq_i;
                        end
                        flash_oe_n <= 1'b1;
                        flash_we_n <= 1'b1;
                        state_q <= BC_HOLD;
                    end
                end
                BC_HOLD: begin
                    // Bus released a cycle before the next cycle starts
                    flash_ce_n <= 1'b1;
                    flash_dq_oe <= 1'b0;
                    done <= 1'b1;
                    state_q <= BC_IDLE;
                end
                default: state_q <= BC_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst || !clk_en);

    AST_STROBES_EXCLUSIVE: assert property (flash_oe_n || flash_we_n)
        else $error("read and write strobes low together");

    AST_READ_STROBE_WIDTH: assert property
        ($fell(flash_oe_n) |-> !flash_oe_n[*2] ##1 flash_oe_n)
        else $error("read strobe width wrong");

endmodule

// File: logic/fws_ctrl.sv
/*
 * Host controller for a multi-bank NOR flash: issues program, erase,
 * suspend, resume and reset sequences and polls write-operation status.
 * Assumes one flash on the pins and inputs synchronous to clk_sys.
 */
// Summary of operation
// - After timing failure host writes reset
// - Confirm acceptance, then read window flag
// - Window flag read before and after add
// - Status reads address the busy bank
// - Status reads use a valid sector address
`timescale 1ns/100ps
module fws_ctrl
    import fws_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [DW-1:0] cmd_data,
    output logic cmd_ready,
    output logic op_done,
    output logic op_failed,
    output logic window_open,
    output logic cmd_rejected,
    output logic [DW-1:0] status_word,
    output logic device_busy,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [AW-1:0] flash_addr,
    output logic [DW-1:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [DW-1:0] flash_dq_i,
    input wire logic ready_busy_out
);

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_WRITE = 9'h002,
        ST_PRE = 9'h004,
        ST_POST = 9'h008,
        ST_POLL_A = 9'h010,
        ST_POLL_B = 9'h020,
        ST_WIN = 9'h040,
        ST_ABORT = 9'h080,
        ST_FIN = 9'h100
    } fws_state_t;

    fws_state_t state_q, state_d;
    fws_op_t op_q;
    logic [AW-1:0] op_addr_q;
    logic [DW-1:0] op_data_q;
    logic [2:0] step_q, step_d;
    logic [2:0] last_q;
    logic [DW-1:0] rd_a_q;
    logic pend_q, start_q, retry_q;
    logic [AW-1:0] seq_addr;
    logic [DW-1:0] seq_data;

    wire logic bus_done;
    wire logic [DW-1:0] bus_rdata;
    wire logic bus_state;
    wire logic bus_wr;
    wire logic launch;
    wire logic [AW-1:0] bus_addr;
    wire logic [DW-1:0] bus_wdata;
    wire logic [AW-1:0] unlock1;
    wire logic [AW-1:0] unlock2;
    wire logic toggled;
    wire logic limit_seen;
    wire logic window_closed;
    wire logic accept;
    wire logic long_seq;

    function automatic logic [DW-1:0] cmd_word(input logic [CMD_W-1:0] c);
        cmd_word = {{(DW-CMD_W){1'b0}}, c};
    endfunction

    assign unlock1 = {{(AW-UNLOCK_W){1'b0}}, ADDR_UNLOCK1};
    assign unlock2 = {{(AW-UNLOCK_W){1'b0}}, ADDR_UNLOCK2};
    assign bus_state = (state_q != ST_IDLE) && (state_q != ST_FIN);
    assign bus_wr = (state_q == ST_WRITE) || (state_q == ST_ABORT);
    assign launch = bus_state && !pend_q && !start_q;
    // Status reads always go to the operation's own address
    assign bus_addr = (state_q == ST_WRITE) ? seq_addr : op_addr_q;
    assign bus_wdata = (state_q == ST_ABORT) ? cmd_word(CMD_RESET)
                                             : seq_data;
    // Only toggle bit one is compared; other positions are don't-care
    assign toggled = rd_a_q[BIT_TOGGLE_ONE] ^ bus_rdata[BIT_TOGGLE_ONE];
    assign limit_seen = bus_rdata[BIT_TIMING_LIMIT];
    assign window_closed = bus_rdata[BIT_ERASE_WINDOW];
    assign accept = cmd_valid && cmd_ready;
    assign long_seq = (cmd_op == OP_PROGRAM) || (cmd_op == OP_SECTOR_ERASE)
                      || (cmd_op == OP_CHIP_ERASE);

    // Command sequence table
    always_comb begin
        seq_addr = unlock1;
        seq_data = cmd_word(CMD_UNLOCK1);
        case (step_q)
            3'h1: begin
                seq_addr = unlock2;
                seq_data = cmd_word(CMD_UNLOCK2);
            end
            3'h2: begin
                seq_data = (op_q == OP_PROGRAM) ? cmd_word(CMD_PROGRAM)
                                                : cmd_word(CMD_ERASE_SETUP);
            end
            3'h3: begin
                if (op_q == OP_PROGRAM) begin
                    seq_addr = op_addr_q;
                    seq_data = op_data_q;
                end
            end
            3'h4: begin
                seq_addr = unlock2;
                seq_data = cmd_word(CMD_UNLOCK2);
            end
            3'h5: begin
                seq_addr = op_addr_q;
                case (op_q)
                    OP_CHIP_ERASE: begin
                        seq_addr = unlock1;
                        seq_data = cmd_word(CMD_CHIP_ERASE);
                    end
                    OP_RESET: seq_data = cmd_word(CMD_RESET);
                    OP_SUSPEND: seq_data = cmd_word(CMD_SUSPEND);
                    OP_RESUME: seq_data = cmd_word(CMD_RESUME);
                    default: seq_data = cmd_word(CMD_SECTOR_ERASE);
                endcase
            end
            default: begin
                seq_addr = unlock1;
                seq_data = cmd_word(CMD_UNLOCK1);
            end
        endcase
    end

    always_comb begin
        state_d = state_q;
        step_d = step_q;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    step_d = long_seq ? STEP_FIRST : STEP_FINAL;
                    case (cmd_op)
                        OP_ADD_SECTOR: state_d = ST_PRE;
                        OP_POLL: state_d = ST_POLL_A;
                        default: state_d = ST_WRITE;
                    endcase
                end
            end
            ST_WRITE: begin
                if (bus_done) begin
                    if (step_q != last_q) begin
                        step_d = step_q + 3'h1;
                    end else begin
                        case (op_q)
                            OP_PROGRAM: state_d = ST_POLL_A;
                            OP_SECTOR_ERASE: state_d = ST_POLL_A;
                            OP_CHIP_ERASE: state_d = ST_POLL_A;
                            OP_ADD_SECTOR: state_d = ST_POST;
                            default: state_d = ST_FIN;
                        endcase
                    end
                end
            end
            ST_PRE: begin
                // A closed window means the add would be ignored
                if (bus_done) begin
                    state_d = window_closed ? ST_FIN : ST_WRITE;
                end
            end
            ST_POST: if (bus_done) state_d = ST_FIN;
            ST_POLL_A: if (bus_done) state_d = ST_POLL_B;
            ST_POLL_B: begin
                if (bus_done) begin
                    if (!toggled) begin
                        state_d = ST_FIN;
                    end else if (op_q == OP_SECTOR_ERASE) begin
                        state_d = ST_WIN;
                    end else if (retry_q) begin
                        state_d = ST_ABORT;
                    end else begin
                        state_d = ST_POLL_A;
                    end
                end
            end
            ST_WIN: if (bus_done) state_d = ST_FIN;
            ST_ABORT: if (bus_done) state_d = ST_FIN;
            ST_FIN: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            step_q <= STEP_FIRST;
            pend_q <= 1'b0;
            start_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            step_q <= step_d;
            start_q <= launch;
            pend_q <= launch ? 1'b1 : (bus_done ? 1'b0 : pend_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            op_q <= OP_POLL;
            op_addr_q <= '0;
            op_data_q <= '0;
            last_q <= STEP_FINAL;
        end else if (clk_en && accept) begin
            op_q <= fws_op_t'(cmd_op);
            op_addr_q <= cmd_addr;
            op_data_q <= cmd_data;
            last_q <= (cmd_op == OP_PROGRAM) ? STEP_PROG_LAST : STEP_FINAL;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_a_q <= '0;
            retry_q <= 1'b0;
            status_word <= '0;
        end else if (clk_en) begin
            if (accept) begin
                retry_q <= 1'b0;
            end else if (bus_done && state_q == ST_POLL_B && limit_seen) begin
                // Toggle may stop just as the limit flag rises: recheck
                retry_q <= 1'b1;
            end
            if (bus_done && !bus_wr) begin
                status_word <= bus_rdata;
            end
            if (bus_done && state_q == ST_POLL_A) begin
                rd_a_q <= bus_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmd_ready <= 1'b0;
            op_done <= 1'b0;
            op_failed <= 1'b0;
            window_open <= 1'b0;
            cmd_rejected <= 1'b0;
            device_busy <= 1'b0;
        end else if (clk_en) begin
            cmd_ready <= (state_d == ST_IDLE);
            op_done <= (state_q == ST_FIN);
            device_busy <= ~ready_busy_out;
            if (accept) begin
                op_failed <= 1'b0;
                cmd_rejected <= 1'b0;
            end
            if (bus_done && state_q == ST_ABORT) begin
                op_failed <= 1'b1;
            end
            if (bus_done && (state_q == ST_PRE || state_q == ST_POST)) begin
                cmd_rejected <= window_closed;
            end
            if (bus_done && (state_q == ST_WIN || state_q == ST_POST)) begin
                window_open <= ~window_closed;
            end
        end
    end

    fws_bus_cycle #(
        .AW(AW),
        .DW(DW)
    ) u_bus (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(start_q),
        .is_write(bus_wr),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .done(bus_done),
        .rdata(bus_rdata),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n),
        .flash_addr(flash_addr),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_i(flash_dq_i)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst || !clk_en);

    sequence s_abort_entered;
        $rose(state_q == ST_ABORT);
    endsequence

    sequence s_reset_written;
        !flash_we_n && flash_dq_oe && flash_dq_o == cmd_word(CMD_RESET);
    endsequence

    AST_RESET_AFTER_FAIL: assert property
        (s_abort_entered |-> ##[1:12] s_reset_written)
        else $error("no reset command after timing failure");

    AST_FAIL_NEEDS_RECHECK: assert property
        ($rose(state_q == ST_ABORT) |-> $past(retry_q))
        else $error("abort without limit recheck");

    AST_STATUS_ADDRESS: assert property
        (!flash_oe_n |-> flash_addr == op_addr_q)
        else $error("status read at wrong address");

    AST_WINDOW_AFTER_TOGGLE: assert property
        ($rose(state_q == ST_WIN) |-> $past(state_q == ST_POLL_B))
        else $error("window flag read before acceptance check");

    AST_ADD_PRECHECK: assert property
        ($rose(state_q == ST_WRITE) && op_q == OP_ADD_SECTOR
         |-> $past(state_q == ST_PRE))
        else $error("sector add without prior window read");

    AST_DONE_THEN_READY: assert property
        (op_done |-> cmd_ready && !flash_dq_oe)
        else $error("done without idle bus");

endmodule

// File: testbench/fws_flash_model.sv
/*
 * Behavioural flash device: command decode, status bits, ready line.
 * Assumes host pins change just after clk_sys rising edges.
 */
`timescale 1ns/100ps
module fws_flash_model
    import fws_pkg::*;
#(
    parameter int PROG_T = 20,
    parameter int WIN_T = 150,
    parameter int ERASE_T = 300
) (
    input wire logic clk_sys,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_dq_o,
    input wire logic flash_dq_oe,
    output logic [DATA_W-1:0] flash_dq_i,
    output logic ready_busy_out
);
    typedef enum int {RD, PG, WN, ER, SU, SP} fws_dst_t;
    fws_dst_t st = RD;
    logic [15:0] mem [logic [22:0]];
    logic [255:0] sel = '0;
    logic [22:0] pa = '0;
    logic [15:0] pd = '0;
    logic [15:0] rq = '0;
    logic we_p = 1'h1, oe_p = 1'h1, tg = 1'h0, fl = 1'h0, arm = 1'h0;
    int seq = 0, pc = 0, ec = 0;

    // Open drain with pull-up: high whenever released
    assign ready_busy_out = (st == RD || st == SU);
    // Released bus shows the inverse, never a stale copy
    assign flash_dq_i = flash_dq_oe ? flash_dq_o :
        (!flash_ce_n && !flash_oe_n) ? rq : ~rq;

    function automatic logic [15:0] ar(input logic [22:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction

    function automatic logic [15:0] vw(input logic [22:0] a);
        logic s;
        logic bk;
        s = sel[a[22:15]];
        bk = |sel[{a[22:21], 6'h00} +: 64];
        if ((st == PG || st == SP) && a[22:21] == pa[22:21])
            return {8'h00, ~pd[7], tg, fl, 5'h00};
        if (st == SU && s)
            return {8'h00, 5'h10, tg, 2'h0};
        if ((st == WN || st == ER) && bk)
            return {8'h00, 1'h0, tg, 2'h0, st == ER, s & tg, 2'h0};
        return ar(a);
    endfunction

    task automatic wr(input logic [22:0] a, input logic [15:0] d);
        logic [7:0] c;
        logic u1;
        logic u2;
        c = d[7:0];
        u1 = a[11:0] == ADDR_UNLOCK1;
        u2 = a[11:0] == ADDR_UNLOCK2;
        if (fl && c == CMD_RESET) begin
            st = (st == SP) ? SU : RD;
            fl = 1'h0;
        end else if (st == ER && c == CMD_SUSPEND) begin
            st = SU;
        end else if (st == WN && c == CMD_SECTOR_ERASE) begin
            sel[a[22:15]] = 1'h1;
            ec = WIN_T;
        end else if (st == SU && seq == 0 && c == CMD_RESUME) begin
            st = ER;
        end else if (st == RD || st == SU) begin
            case (seq)
                0, 4: seq = (u1 && c == CMD_UNLOCK1) ? seq + 1 : 0;
                1, 5: seq = (u2 && c == CMD_UNLOCK2) ? seq + 1 : 0;
                2: seq = (c == CMD_PROGRAM) ? 3 :
                    (c == CMD_ERASE_SETUP && st == RD) ? 4 : 0;
                3: begin
                    pa = a;
                    pd = d;
                    arm = |(d & ~ar(a));
                    mem[a] = ar(a) & d;
                    st = (st == SU) ? SP : PG;
                    pc = PROG_T;
                    seq = 0;
                end
                default: begin
                    seq = 0;
                    if (c == CMD_SECTOR_ERASE) begin
                        sel[a[22:15]] = 1'h1;
                        st = WN;
                        ec = WIN_T;
                    end else if (c == CMD_CHIP_ERASE) begin
                        sel = '1;
                        st = ER;
                        ec = ERASE_T;
                    end
                end
            endcase
        end
    endtask

    always @(posedge clk_sys) begin
        if (!flash_ce_n && flash_we_n && !we_p)
            wr(flash_addr, flash_dq_o);
        if (!flash_ce_n && !flash_oe_n && oe_p) begin
            tg = ~tg;
            rq = vw(flash_addr);
        end
        if (pc > 0) begin
            pc--;
            if (pc == 0 && arm)
                fl = 1'h1;
            else if (pc == 0)
                st = (st == SP) ? SU : RD;
        end
        if (ec > 0 && (st == WN || st == ER)) begin
            ec--;
            if (ec == 0 && st == WN) begin
                st = ER;
                ec = ERASE_T;
            end else if (ec == 0) begin
                foreach (mem[k])
                    if (sel[k[22:15]])
                        mem[k] = 16'hFFFF;
                sel = '0;
                st = RD;
            end
        end
        we_p = flash_we_n;
        oe_p = flash_oe_n;
    end
endmodule

// File: testbench/fws_ctrl_bench.sv
/*
 * Self-checking bench: fws_ctrl driving the behavioural flash model.
 * Assumes the model's short program, window and erase times.
 */
`timescale 1ns/100ps
module fws_ctrl_bench
    import fws_pkg::*;
;
    typedef struct {
        logic [5:0] c;
        logic [15:0] m;
        logic [15:0] v;
    } fws_note_t;
    logic clk_sys = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, cmd_valid = 1'h0;
    logic [2:0] cmd_op = 3'h0;
    logic [ADDR_W-1:0] cmd_addr = '0, flash_addr;
    logic [DATA_W-1:0] cmd_data = '0, status_word, flash_dq_o, flash_dq_i;
    logic cmd_ready, op_done, op_failed, window_open, cmd_rejected;
    logic device_busy, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    logic ready_busy_out;
    fws_note_t exq[$];
    fws_note_t e;
    int n_mismatch = 0, compares = 0, cyc = 0, seed = 90510, i;
    logic [22:0] pa0, es, os;
    logic [15:0] pd0, od, gd;
    logic [15:0] z = 16'h0000;

    always #25 clk_sys = ~clk_sys;

    fws_ctrl dut_u (
        .clk_sys, .sys_rst, .clk_en, .cmd_valid, .cmd_op, .cmd_addr,
        .cmd_data, .cmd_ready, .op_done, .op_failed, .window_open,
        .cmd_rejected, .status_word, .device_busy, .flash_ce_n,
        .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_o, .flash_dq_oe,
        .flash_dq_i, .ready_busy_out
    );
    fws_flash_model dev_u (
        .clk_sys, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
        .flash_dq_o, .flash_dq_oe, .flash_dq_i, .ready_busy_out
    );

    task automatic check(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Flags: check window, check busy, then failed, window, rejected, busy
    task automatic go(input logic [2:0] op, input logic [22:0] a,
        input logic [15:0] d, input logic [5:0] c, input logic [15:0] m, v);
        int k;
        exq.push_back('{c, m, v});
        @(negedge clk_sys);
        cmd_valid = 1'h1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        while (cmd_ready !== 1'h1)
            @(negedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'h0;
        k = 0;
        while (op_done !== 1'h1 && k < 20000) begin
            @(negedge clk_sys);
            k++;
        end
    endtask

    always @(negedge clk_sys) begin
        if (op_done === 1'h1) begin
            e = exq.pop_front();
            check("op_failed", 16'(op_failed), 16'(e.c[3]));
            check("cmd_rejected", 16'(cmd_rejected), 16'(e.c[1]));
            if (e.c[5])
                check("window_open", 16'(window_open), 16'(e.c[2]));
            if (e.c[4])
                check("device_busy", 16'(device_busy), 16'(e.c[0]));
            check("status_word", status_word & e.m, e.v);
        end
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'h0;
        for (i = 0; i < 4; i++) begin
            pa0 = {2'h1, 21'($random(seed))};
            pd0 = 16'($random(seed));
            go(OP_PROGRAM, pa0, pd0, 6'h10, 16'hFFFF, pd0);
            go(OP_POLL, pa0, z, 6'h10, 16'hFFFF, pd0);
        end
        $display("test program done");
        es = {2'h2, 6'h05, 15'h0000};
        os = {2'h2, 6'h09, 15'h0040};
        od = 16'($random(seed));
        go(OP_PROGRAM, es + 23'h1, z, 6'h00, z, z);
        go(OP_PROGRAM, es + 23'h1, 16'hFFFF, 6'h08, z, z);
        go(OP_POLL, es + 23'h1, z, 6'h10, 16'hFFFF, z);
        go(OP_PROGRAM, os, od, 6'h10, 16'hFFFF, od);
        $display("test failure done");
        go(OP_SECTOR_ERASE, es, z, 6'h35, 16'h0088, z);
        repeat (90) @(negedge clk_sys);
        go(OP_ADD_SECTOR, es + 23'h8000, z, 6'h24, 16'h0008, z);
        repeat (90) @(negedge clk_sys);
        go(OP_ADD_SECTOR, es + 23'h10000, z, 6'h24, 16'h0008, z);
        go(OP_POLL, es + 23'h1, z, 6'h10, 16'hFFFF, 16'hFFFF);
        $display("test window done");
        go(OP_SECTOR_ERASE, es, z, 6'h24, z, z);
        repeat (170) @(negedge clk_sys);
        go(OP_ADD_SECTOR, es + 23'h8000, z, 6'h26, 16'h00A8, 16'h0008);
        go(OP_POLL, pa0, z, 6'h00, 16'hFFFF, pd0);
        go(OP_SUSPEND, es, z, 6'h10, z, z);
        go(OP_POLL, es, z, 6'h00, 16'hFFBB, 16'h0080);
        go(OP_POLL, os, z, 6'h00, 16'hFFFF, od);
        gd = 16'($random(seed));
        go(OP_PROGRAM, os + 23'h1, gd, 6'h10, 16'hFFFF, gd);
        go(OP_RESUME, es, z, 6'h00, z, z);
        go(OP_POLL, es, z, 6'h10, 16'hFFFF, 16'hFFFF);
        $display("test suspend done");
        go(OP_CHIP_ERASE, es, z, 6'h00, z, z);
        go(OP_POLL, pa0, z, 6'h10, 16'hFFFF, 16'hFFFF);
        go(OP_RESET, es, z, 6'h00, z, z);
        $display("test chip erase done");
        // Mid-run reset: window flag returns to 0 through reset or a closed-window read in ST_WIN or ST_POST
        @(negedge clk_sys);
        sys_rst = 1'h1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'h0;
        go(OP_POLL, pa0, z, 6'h30, 16'hFFFF, 16'hFFFF);
        $display("test reset done");
        close_out();
    end
endmodule
